/* File: reset_and_standby_control.sv */
// Chosen here: strobed register access.
`timescale 1ns/10ps
module reset_and_standby_control
  import reset_standby_pkg::*;
#(
  parameter int WDT_CYCLES_0 = WDT_MS_0 * CLK_KHZ,
  parameter int WDT_CYCLES_1 = WDT_MS_1 * CLK_KHZ,
  parameter int WDT_CYCLES_2 = WDT_MS_2 * CLK_KHZ,
  parameter int WDT_CYCLES_3 = WDT_MS_3 * CLK_KHZ
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,

  // reset sources
  input  wire logic        reset_pin_n,
  input  wire logic        por_detect,
  input  wire logic        supply_monitor_reset,
  input  wire logic        wdt_second_overflow,
  input  wire logic        break_instruction,

  // core status
  input  wire logic [1:0]  interrupt_level_field,
  input  wire logic        irq_pending,
  input  wire logic        wdt_irq,

  // register port
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,

  // reset and vector outputs
  output logic             core_reset,
  output logic             sfr_reset,
  output logic [15:0]      sp_vector_addr,
  output logic [15:0]      pc_vector_addr,
  output logic             vector_load,

  // operating mode
  output logic [1:0]       op_mode,
  output logic             halt_active,
  output logic             stop_active,
  output logic             stop_accept_en,

  // watchdog period
  output logic [1:0]       wdt_period_sel,
  output logic [31:0]      wdt_period_cycles,

  // peripherals: uart, adc, timer 8,9,A,B,E,F, pwm
  output logic [8:0]       periph_reset,
  output logic [8:0]       periph_clk_en
);

  localparam logic [15:0] HOLD_LOAD = 16'(RESET_HOLD_CYCLES);

  // ==========================================================
  // source synchronisation
  logic [2:0]  pin_sync;
  logic        pin_rst;
  logic        por_rst;
  logic        sup_rst;
  logic        hard_src;
  logic        any_src;

  two_stage_sync #(
    .WIDTH    (3)
  ) u_sync (
    .clk      (clk),
    .rstn     (rstn),
    .async_in ({supply_monitor_reset, por_detect, ~reset_pin_n}),
    .sync_out (pin_sync)
  );

  assign pin_rst  = pin_sync[0];
  assign por_rst  = pin_sync[1];
  assign sup_rst  = pin_sync[2];
  assign hard_src = pin_rst | por_rst | sup_rst | wdt_second_overflow;
  assign any_src  = hard_src | break_instruction;

  // ==========================================================
  // register decode
  logic        wr_cause;
  logic        wr_unlock;
  logic        wr_standby;
  logic        wr_wdt;
  logic [3:0]  wr_blk;

  assign wr_cause   = reg_wr && reg_addr == ADDR_RESET_CAUSE;
  assign wr_unlock  = reg_wr && reg_addr == ADDR_STOP_UNLOCK;
  assign wr_standby = reg_wr && reg_addr == ADDR_STANDBY;
  assign wr_wdt     = reg_wr && reg_addr == ADDR_WDT_PERIOD;

  for (genvar b = 0; b < 4; b++) begin : g_blk_dec
    assign wr_blk[b] = reg_wr && reg_addr == ADDR_BLK[b];
  end

  // ==========================================================
  // reset hold and break tracking
  logic [15:0] hold_cnt;
  logic        by_break;
  op_mode_e    mode;

  // pulses are stretched so the core sees a full reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hold_cnt <= HOLD_LOAD;
    end else if (any_src) begin
      hold_cnt <= HOLD_LOAD;
    end else if (hold_cnt != 16'h0000) begin
      hold_cnt <= hold_cnt - 16'h0001;
    end
  end

  // a hard source seen at any time makes the whole reset full
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      by_break <= 1'b0;
    end else if (hard_src) begin
      by_break <= 1'b0;
    end else if (break_instruction && mode != MODE_RESET) begin
      by_break <= 1'b1;
    end
  end

  // ==========================================================
  // operating state
  logic        stop_go;
  logic        halt_go;
  logic        leave_reset;

  // prohibited 11 and pending interrupts leave the mode alone
  assign stop_go = wr_standby && reg_wdata[SBY_STOP_BIT] && !reg_wdata[SBY_HALT_BIT]
                   && stop_accept_en && !irq_pending;
  assign halt_go = wr_standby && reg_wdata[SBY_HALT_BIT] && !reg_wdata[SBY_STOP_BIT]
                   && !irq_pending;
  assign leave_reset = mode == MODE_RESET && hold_cnt == 16'h0000;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode <= MODE_RESET;
    end else if (any_src) begin
      mode <= MODE_RESET;
    end else begin
      case (mode)
        MODE_RESET: begin
          if (hold_cnt == 16'h0000) begin
            mode <= MODE_RUN;
          end
        end
        MODE_RUN: begin
          if (stop_go) begin
            mode <= MODE_STOP;
          end else if (halt_go) begin
            mode <= MODE_HALT;
          end
        end
        MODE_HALT: begin
          if (wdt_irq || irq_pending) begin
            mode <= MODE_RUN;
          end
        end
        MODE_STOP: begin
          if (irq_pending) begin
            mode <= MODE_RUN;
          end
        end
        default: begin
          mode <= MODE_RESET;
        end
      endcase
    end
  end

  assign op_mode     = mode;
  assign core_reset  = mode == MODE_RESET;
  assign halt_active = mode == MODE_HALT;
  assign stop_active = mode == MODE_STOP;

  // flopped, not decoded: mode and the break flag move on one edge and would glitch it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sfr_reset <= 1'b1;
    end else if (hard_src) begin
      sfr_reset <= 1'b1;
    end else if (break_instruction && mode != MODE_RESET) begin
      sfr_reset <= 1'b0;
    end else begin
      sfr_reset <= (break_instruction || (mode == MODE_RESET && hold_cnt != 16'h0000))
                   && !by_break;
    end
  end

  // ==========================================================
  // vectors
  assign sp_vector_addr = VEC_SP_ADDR;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pc_vector_addr <= VEC_PC_ADDR;
    end else if (hard_src) begin
      pc_vector_addr <= VEC_PC_ADDR;
    end else if (break_instruction && mode != MODE_RESET) begin
      pc_vector_addr <= (interrupt_level_field <= BRK_LEVEL_MAX)
                        ? VEC_BRK_ADDR : VEC_PC_ADDR;
    end
  end

  // one pulse as the core leaves reset and fetches both words
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vector_load <= 1'b0;
    end else begin
      vector_load <= leave_reset && !any_src;
    end
  end

  // ==========================================================
  // stop acceptor
  logic        unlock_clear;

  // cleared on the edge a source hits, so no reset cycle sees it armed
  assign unlock_clear = core_reset | any_src;

  stop_unlock u_unlock (
    .clk          (clk),
    .rstn         (rstn),
    .sys_reset    (unlock_clear),
    .wr_strobe    (wr_unlock),
    .wdata        (reg_wdata),
    .irq_pending  (irq_pending),
    .stop_entered (stop_go),
    .accept_en    (stop_accept_en)
  );

  // ==========================================================
  // reset cause: power-up sets only the power-on flag
  logic [7:0]  cause;
  logic [7:0]  cause_set;
  logic [7:0]  next_cause;

  always_comb begin
    cause_set                   = 8'h00;
    cause_set[CAUSE_POR_BIT]    = por_rst;
    cause_set[CAUSE_WDT_BIT]    = wdt_second_overflow;
    cause_set[CAUSE_SUPPLY_BIT] = sup_rst;
  end

  // pin reset sets nothing; a new cause beats a clearing write
  always_comb begin
    next_cause = wr_cause ? (reg_wdata & CAUSE_MASK) : cause;
    next_cause = next_cause | cause_set;
  end

  // no system-reset branch: software owns the contents
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cause <= CAUSE_POWER_ON;
    end else begin
      cause <= next_cause;
    end
  end

  // ==========================================================
  // block control and watchdog period
  logic [3:0][7:0] blk;

  for (genvar b = 0; b < 4; b++) begin : g_blk
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        blk[b] <= BLK_RESET;
      end else if (sfr_reset) begin
        blk[b] <= BLK_RESET;
      end else if (wr_blk[b]) begin
        blk[b] <= reg_wdata & BLK_MASK[b];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wdt_period_sel <= WDT_SEL_RESET;
    end else if (sfr_reset) begin
      wdt_period_sel <= WDT_SEL_RESET;
    end else if (wr_wdt) begin
      wdt_period_sel <= reg_wdata[1:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wdt_period_cycles <= 32'(WDT_CYCLES_0);
    end else begin
      case (wdt_period_sel)
        2'h0:    wdt_period_cycles <= 32'(WDT_CYCLES_0);
        2'h1:    wdt_period_cycles <= 32'(WDT_CYCLES_1);
        2'h2:    wdt_period_cycles <= 32'(WDT_CYCLES_2);
        default: wdt_period_cycles <= 32'(WDT_CYCLES_3);
      endcase
    end
  end

  // disabled blocks sit in reset with clocks stopped
  logic [8:0] blk_off;

  assign blk_off = {blk[3][0], blk[2][7], blk[2][6], blk[2][3], blk[2][2],
                    blk[2][1], blk[2][0], blk[1][0], blk[0][2]};

  for (genvar p = 0; p < 9; p++) begin : g_periph
    assign periph_reset[p]  = blk_off[p] | sfr_reset;
    assign periph_clk_en[p] = ~blk_off[p];
  end

  // ==========================================================
  // read port: write-only locations answer zero
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = RD_ZERO;
    case (reg_addr)
      ADDR_RESET_CAUSE: next_rdata = cause & CAUSE_MASK;
      ADDR_BLK[0]:      next_rdata = blk[0];
      ADDR_BLK[1]:      next_rdata = blk[1];
      ADDR_BLK[2]:      next_rdata = blk[2];
      ADDR_BLK[3]:      next_rdata = blk[3];
      ADDR_WDT_PERIOD:  next_rdata = {6'h00, wdt_period_sel};
      ADDR_MODE_STATUS: next_rdata = {4'h0, by_break, stop_accept_en, mode};
      default:          next_rdata = RD_ZERO;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= RD_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= RD_ZERO;
    end
  end

endmodule : reset_and_standby_control

/* File: reset_standby_pkg.sv */
// Function
// - any of five sources enters system reset
// - watchdog second overflow period: four choices
// - break reset touches core only
// - cause register kept; matching flag set
// - bit 0 flags power-on reset
// - bit 2 flags watchdog reset
// - bit 5 flags supply monitor reset
// - reset pin records no cause flag
// - reset overrides and abandons all activity
// - reset loads register defaults, except break
// - stack pointer from words 0000H/0001H
// - program counter vector; break low level uses 0004H
// - data memory and undefined registers untouched
// - other value after 5n cancels sequence
// - stop bit with acceptor enters STOP
// - acceptor disabled during system reset
// - no enable while interrupt pending
// - four states: reset, run, halt, stop
// - block control resets and gates peripherals
// - standby bits: 00 run, 01 halt, 10 stop
// - interrupt ends stop; halt ends on interrupt
package reset_standby_pkg;

  // ==========================================================
  // register map
  localparam logic [15:0] ADDR_RESET_CAUSE   = 16'hF001;
  localparam logic [15:0] ADDR_STOP_UNLOCK   = 16'hF008;
  localparam logic [15:0] ADDR_STANDBY       = 16'hF009;
  localparam logic [15:0] ADDR_WDT_PERIOD    = 16'hF0F0;
  localparam logic [15:0] ADDR_MODE_STATUS   = 16'hF0F1;
  localparam logic [3:0][15:0] ADDR_BLK      = {16'hF02F, 16'hF02E, 16'hF02C, 16'hF02A};
  localparam logic [3:0][7:0]  BLK_MASK      = {8'h01, 8'hCF, 8'h01, 8'h04};
  localparam logic [7:0]  BLK_RESET          = 8'h00;
  localparam logic [7:0]  RD_ZERO            = 8'h00;

  // ==========================================================
  // reset cause fields
  localparam int          CAUSE_POR_BIT      = 0;
  localparam int          CAUSE_WDT_BIT      = 2;
  localparam int          CAUSE_SUPPLY_BIT   = 5;
  localparam logic [7:0]  CAUSE_MASK         = 8'h25;
  localparam logic [7:0]  CAUSE_POWER_ON     = 8'h01;

  // ==========================================================
  // standby and unlock codes
  localparam int          SBY_STOP_BIT       = 1;
  localparam int          SBY_HALT_BIT       = 0;
  localparam logic [3:0]  UNLOCK_FIRST       = 4'h5;
  localparam logic [3:0]  UNLOCK_SECOND      = 4'hA;

  // ==========================================================
  // vectors
  localparam logic [15:0] VEC_SP_ADDR        = 16'h0000;
  localparam logic [15:0] VEC_PC_ADDR        = 16'h0002;
  localparam logic [15:0] VEC_BRK_ADDR       = 16'h0004;
  localparam logic [1:0]  BRK_LEVEL_MAX      = 2'h1;

  // ==========================================================
  // timing
  localparam int          CLK_KHZ            = 40000;
  localparam int          RESET_HOLD_NS      = 1000;
  localparam int          RESET_HOLD_CYCLES  = (RESET_HOLD_NS * CLK_KHZ + 999999) / 1000000;
  localparam int          WDT_MS_0           = 250;
  localparam int          WDT_MS_1           = 1000;
  localparam int          WDT_MS_2           = 4000;
  localparam int          WDT_MS_3           = 16000;
  localparam logic [1:0]  WDT_SEL_RESET      = 2'h0;

  typedef enum logic [1:0] {
    MODE_RESET = 2'b00,
    MODE_RUN   = 2'b01,
    MODE_HALT  = 2'b10,
    MODE_STOP  = 2'b11
  } op_mode_e;

endpackage : reset_standby_pkg

/* File: two_stage_sync.sv */
`timescale 1ns/10ps
module two_stage_sync #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_one;

  // ==========================================================
  // one pair of flops per bit
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        stage_one[i] <= 1'b0;
        sync_out[i]  <= 1'b0;
      end else begin
        stage_one[i] <= async_in[i];
        sync_out[i]  <= stage_one[i];
      end
    end
  end

endmodule : two_stage_sync

/* File: stop_unlock.sv */
`timescale 1ns/10ps
module stop_unlock
  import reset_standby_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // control
  input  wire logic       sys_reset,
  input  wire logic       wr_strobe,
  input  wire logic [7:0] wdata,
  input  wire logic       irq_pending,
  input  wire logic       stop_entered,
  // state
  output logic            accept_en
);

  logic first_seen;

  // ==========================================================
  // two-write sequence; other bus traffic leaves it alone
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      first_seen <= 1'b0;
    end else if (sys_reset) begin
      first_seen <= 1'b0;
    end else if (wr_strobe) begin
      first_seen <= (wdata[7:4] == UNLOCK_FIRST);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      accept_en <= 1'b0;
    end else if (sys_reset || stop_entered) begin
      accept_en <= 1'b0;
    end else if (wr_strobe && first_seen && wdata[7:4] == UNLOCK_SECOND
                 && !irq_pending) begin
      accept_en <= 1'b1;
    end
  end

endmodule : stop_unlock

/* File: rsc_chk.sv */
`timescale 1ns/10ps
module rsc_chk
  import reset_standby_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // block inputs
  input wire logic        reset_pin_n,
  input wire logic        wdt_second_overflow,
  input wire logic        break_instruction,
  input wire logic        irq_pending,
  input wire logic        wdt_irq,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  // block outputs
  input wire logic [7:0]  reg_rdata,
  input wire logic        core_reset,
  input wire logic [1:0]  op_mode,
  input wire logic        stop_accept_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // ==========
  // unlock steps
  sequence first_s;
    reg_wr && reg_addr == ADDR_STOP_UNLOCK && reg_wdata[7:4] == UNLOCK_FIRST
      && op_mode == MODE_RUN;
  endsequence
  sequence gap_s;
    op_mode == MODE_RUN && !(reg_wr && reg_addr == ADDR_STOP_UNLOCK);
  endsequence
  sequence second_s;
    reg_wr && reg_addr == ADDR_STOP_UNLOCK && reg_wdata[7:4] == UNLOCK_SECOND && !irq_pending
      && op_mode == MODE_RUN && !wdt_second_overflow && !break_instruction;
  endsequence

  // ==========
  // acceptor
  unlock_arms_a: assert property (first_s ##1 gap_s ##1 second_s
    ##1 op_mode == MODE_RUN |-> stop_accept_en)
    else $error("unlock pair did not arm acceptor");
  wrong_byte_a: assert property (!stop_accept_en && reg_wr && reg_addr == ADDR_STOP_UNLOCK
    && reg_wdata[7:4] != UNLOCK_SECOND |=> !stop_accept_en)
    else $error("acceptor armed by wrong byte");
  pending_blocks_a: assert property (!stop_accept_en && irq_pending |=> !stop_accept_en)
    else $error("acceptor armed with interrupt pending");
  reset_disarms_a: assert property (core_reset |-> !stop_accept_en)
    else $error("acceptor enabled during reset");
  stop_disarms_a: assert property ($rose(op_mode == MODE_STOP) |-> !stop_accept_en)
    else $error("acceptor still enabled in stop");

  // ==========
  // modes
  stop_entry_a: assert property (stop_accept_en && reg_wr && reg_addr == ADDR_STANDBY
    && reg_wdata[1:0] == 2'b10 && !irq_pending && op_mode == MODE_RUN
    |=> op_mode inside {MODE_STOP, MODE_RESET})
    else $error("stop request not taken");
  both_bits_a: assert property (reg_wr && reg_addr == ADDR_STANDBY && reg_wdata[1:0] == 2'b11
    && op_mode == MODE_RUN |=> op_mode inside {MODE_RUN, MODE_RESET})
    else $error("prohibited standby code changed mode");
  wake_up_a: assert property ((op_mode == MODE_STOP || op_mode == MODE_HALT) && irq_pending
    || op_mode == MODE_HALT && wdt_irq |=> op_mode inside {MODE_RUN, MODE_RESET})
    else $error("standby not left on wake request");

  // ==========
  // reset and reads
  source_reset_a: assert property (wdt_second_overflow
    || break_instruction && op_mode == MODE_RUN |=> core_reset)
    else $error("reset source ignored");
  pin_reset_a: assert property (!reset_pin_n [*3] |-> ##[1:2] core_reset)
    else $error("reset pin ignored");
  read_zero_a: assert property (reg_rd
    && (reg_addr == ADDR_STOP_UNLOCK || reg_addr == ADDR_STANDBY) |=> reg_rdata == RD_ZERO)
    else $error("write-only register read nonzero");
  cause_unused_a: assert property (reg_rd && reg_addr == ADDR_RESET_CAUSE
    |=> (reg_rdata & ~CAUSE_MASK) == 8'h00)
    else $error("unused cause bits nonzero");
endmodule : rsc_chk

bind reset_and_standby_control rsc_chk i_rsc_chk (.clk, .rstn, .reset_pin_n,
  .wdt_second_overflow, .break_instruction, .irq_pending, .wdt_irq, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .core_reset, .op_mode, .stop_accept_en);

/* File: core_model.sv */
`timescale 1ns/10ps
module core_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // from the block
  input  wire logic        core_reset,
  input  wire logic        vector_load,
  input  wire logic [15:0] pc_vector_addr,
  // bench commands
  input  wire logic        brk_cmd,
  input  wire logic [1:0]  brk_level,
  input  wire logic        irq_cmd,
  // to the block; pc_loaded to the bench
  output logic             break_instruction,
  output logic [1:0]       interrupt_level_field,
  output logic             irq_pending,
  output logic [15:0]      pc_loaded
);
  // ==========
  // core side
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      break_instruction     <= 1'b0;
      interrupt_level_field <= 2'h0;
      irq_pending           <= 1'b0;
      pc_loaded             <= 16'h0000;
    end else begin
      // a core held in reset executes nothing
      break_instruction     <= brk_cmd && !core_reset;
      interrupt_level_field <= brk_level;
      irq_pending           <= irq_cmd;
      if (vector_load) begin
        pc_loaded <= pc_vector_addr;
      end
    end
  end
endmodule : core_model

/* File: tb.sv */
`timescale 1ns/10ps
module tb
  import reset_standby_pkg::*;
;
  logic        clk, rstn, reset_pin_n, por_detect, supply_monitor_reset, wdt_second_overflow;
  logic        wdt_irq, reg_wr, reg_rd, vector_load, core_reset, sfr_reset, brk_cmd, irq_cmd;
  logic        break_instruction, irq_pending, halt_active, stop_active, stop_accept_en;
  logic [1:0]  interrupt_level_field, op_mode, wdt_period_sel, brk_level;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [15:0] reg_addr, sp_vector_addr, pc_vector_addr, pc_loaded;
  logic [31:0] wdt_period_cycles;
  logic [8:0]  periph_reset, periph_clk_en;
  int          failures, checks_done;

  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  // short watchdog periods keep the run brief
  reset_and_standby_control #(.WDT_CYCLES_0(16), .WDT_CYCLES_1(32), .WDT_CYCLES_2(64),
    .WDT_CYCLES_3(128)) i_reset_and_standby_control (.clk, .rstn, .reset_pin_n, .por_detect,
    .supply_monitor_reset, .wdt_second_overflow, .break_instruction, .interrupt_level_field,
    .irq_pending, .wdt_irq, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .core_reset,
    .sfr_reset, .sp_vector_addr, .pc_vector_addr, .vector_load, .op_mode, .halt_active,
    .stop_active, .stop_accept_en, .wdt_period_sel, .wdt_period_cycles, .periph_reset,
    .periph_clk_en);
  core_model i_core_model (.clk, .rstn, .core_reset, .vector_load, .pc_vector_addr, .brk_cmd,
    .brk_level, .irq_cmd, .break_instruction, .interrupt_level_field, .irq_pending, .pc_loaded);

  // ==========
  // tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    @(negedge clk);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(negedge clk);
    chk($sformatf("read %h", a), 32'(exp), 32'(reg_rdata));
  endtask : rd

  task automatic wait_run();
    int n;
    n = 0;
    while (op_mode !== MODE_RUN && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (op_mode !== MODE_RUN) begin
      failures++;
      summarize();
    end
    repeat (3) @(negedge clk);
  endtask : wait_run

  // source 0 pin, 1 power-on, 2 supply, 3 watchdog, 4 break
  task automatic hit(input int k, input logic sfr_exp);
    @(posedge clk);
    case (k)
      0: reset_pin_n <= 1'b0;
      1: por_detect <= 1'b1;
      2: supply_monitor_reset <= 1'b1;
      3: wdt_second_overflow <= 1'b1;
      default: brk_cmd <= 1'b1;
    endcase
    repeat (3) @(posedge clk);
    reset_pin_n          <= 1'b1;
    por_detect           <= 1'b0;
    supply_monitor_reset <= 1'b0;
    wdt_second_overflow  <= 1'b0;
    brk_cmd              <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("core_reset", 32'h1, 32'(core_reset));
    chk("sfr_reset", 32'(sfr_exp), 32'(sfr_reset));
    wait_run();
  endtask : hit

  task automatic summarize();
    $display("checks_done=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  // ==========
  // sequence
  initial begin
    failures = 0;
    checks_done = 0;
    {reset_pin_n, rstn, por_detect, supply_monitor_reset, wdt_second_overflow} = 5'b10000;
    {wdt_irq, reg_wr, reg_rd, brk_cmd, irq_cmd} = 5'b00000;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    brk_level = 2'h1;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    wait_run();
    rd(ADDR_RESET_CAUSE, CAUSE_POWER_ON);
    for (int i = 0; i < 4; i++) rd(ADDR_BLK[i], BLK_RESET);
    rd(ADDR_STOP_UNLOCK, RD_ZERO);
    rd(ADDR_STANDBY, RD_ZERO);
    rd(16'hF0FF, RD_ZERO);
    wr(ADDR_RESET_CAUSE, 8'hFF);
    rd(ADDR_RESET_CAUSE, CAUSE_MASK);
    wr(ADDR_RESET_CAUSE, 8'h00);
    rd(ADDR_RESET_CAUSE, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_WDT_PERIOD, 8'(i));
      rd(ADDR_WDT_PERIOD, 8'(i));
      repeat (2) @(negedge clk);
      chk("wdt_period_cycles", 32'(16 << i), wdt_period_cycles);
      wr(ADDR_BLK[i], 8'hFF);
      rd(ADDR_BLK[i], BLK_MASK[i]);
    end
    chk("periph_reset", 32'h1FF, 32'(periph_reset));
    chk("periph_clk_en", 32'h0, 32'(periph_clk_en));
    hit(4, 1'b0);
    chk("pc_loaded", 32'(VEC_BRK_ADDR), 32'(pc_loaded));
    chk("sp_vector_addr", 32'(VEC_SP_ADDR), 32'(sp_vector_addr));
    rd(ADDR_MODE_STATUS, {4'h0, 1'b1, 1'b0, MODE_RUN});
    rd(ADDR_BLK[2], BLK_MASK[2]);
    rd(ADDR_RESET_CAUSE, 8'h00);
    brk_level <= 2'h2;
    hit(4, 1'b0);
    chk("pc_loaded", 32'(VEC_PC_ADDR), 32'(pc_loaded));
    hit(3, 1'b1);
    rd(ADDR_RESET_CAUSE, 8'h04);
    rd(ADDR_BLK[2], BLK_RESET);
    chk("periph_clk_en", 32'h1FF, 32'(periph_clk_en));
    hit(2, 1'b1);
    rd(ADDR_RESET_CAUSE, 8'h24);
    wr(ADDR_RESET_CAUSE, 8'h00);
    hit(0, 1'b1);
    rd(ADDR_RESET_CAUSE, 8'h00);
    hit(1, 1'b1);
    rd(ADDR_RESET_CAUSE, CAUSE_POWER_ON);
    wr(ADDR_STANDBY, 8'h02);
    chk("op_mode", 32'(MODE_RUN), 32'(op_mode));
    wr(ADDR_STOP_UNLOCK, 8'h53);
    wr(ADDR_STOP_UNLOCK, 8'h3A);
    wr(ADDR_STOP_UNLOCK, 8'hA5);
    chk("stop_accept_en", 32'h0, 32'(stop_accept_en));
    wr(ADDR_STOP_UNLOCK, 8'h5F);
    wr(ADDR_RESET_CAUSE, 8'h00);
    wr(ADDR_STOP_UNLOCK, 8'hA0);
    chk("stop_accept_en", 32'h1, 32'(stop_accept_en));
    wr(ADDR_STANDBY, 8'h02);
    chk("op_mode", 32'(MODE_STOP), 32'(op_mode));
    chk("stop_active", 32'h1, 32'(stop_active));
    chk("stop_accept_en", 32'h0, 32'(stop_accept_en));
    @(posedge clk);
    irq_cmd <= 1'b1;
    repeat (3) @(negedge clk);
    chk("op_mode", 32'(MODE_RUN), 32'(op_mode));
    wr(ADDR_STOP_UNLOCK, 8'h50);
    wr(ADDR_STOP_UNLOCK, 8'hA0);
    chk("stop_accept_en", 32'h0, 32'(stop_accept_en));
    @(posedge clk);
    irq_cmd <= 1'b0;
    wr(ADDR_STANDBY, 8'h01);
    chk("halt_active", 32'h1, 32'(halt_active));
    @(posedge clk);
    wdt_irq <= 1'b1;
    @(posedge clk);
    wdt_irq <= 1'b0;
    repeat (2) @(negedge clk);
    chk("op_mode", 32'(MODE_RUN), 32'(op_mode));
    wr(ADDR_STANDBY, 8'h03);
    chk("op_mode", 32'(MODE_RUN), 32'(op_mode));
    wr(ADDR_STOP_UNLOCK, 8'h50);
    wr(ADDR_STOP_UNLOCK, 8'hA0);
    chk("stop_accept_en", 32'h1, 32'(stop_accept_en));
    hit(4, 1'b0);
    chk("stop_accept_en", 32'h0, 32'(stop_accept_en));
    summarize();
  end
endmodule : tb
